// file: common/flme_cfg.svh
/*
  Constants of the flag, move and load execution block: register offsets,
  status flag positions, pointer register indices and reset values.
  Assumes it is included by bare name after the package.
*/
// Functional notes
// - Copy-bit-to-transfer-flag puts the chosen source bit into T, touches no other flag, one cycle.
// - Copy-transfer-flag-to-bit puts T into the chosen destination bit, no flag changes, one cycle.
// - Interrupts-on sets the global interrupt enable flag in one cycle and nothing else.
// - Interrupts-off clears the global interrupt enable flag in one cycle and nothing else.
// - Sign flag raise sets S and sign flag lower clears S, one cycle each, nothing else.
// - Overflow flag raise sets V in one cycle and nothing else.
// - Overflow flag lower clears V in one cycle and nothing else.
// - Half carry raise sets H in one cycle and nothing else.
// - Half carry lower clears H in one cycle and nothing else.
// - Register copy moves the source register into the destination in one cycle, no flags.
// - Post-increment load via X or Y reads memory at the pointer, then bumps it, two cycles.
// - Pre-decrement load via X or Y drops the pointer first, then reads there, two cycles.
// - Displaced load via Y reads at Y plus displacement, Y unchanged, two cycles, no flags.
`ifndef FLME_CFG_SVH
`define FLME_CFG_SVH
`define FLME_ADDR_INSTR 8'h00
`define FLME_ADDR_STATUS 8'h04
`define FLME_ADDR_SEL 8'h08
`define FLME_ADDR_GPR 8'h0C
`define FLME_RESP_OKAY 2'h0
`define FLME_RESP_SLVERR 2'h2
`define FLME_FLAG_C 3'h0
`define FLME_FLAG_Z 3'h1
`define FLME_FLAG_N 3'h2
`define FLME_FLAG_V 3'h3
`define FLME_FLAG_S 3'h4
`define FLME_FLAG_H 3'h5
`define FLME_FLAG_T 3'h6
`define FLME_FLAG_I 3'h7
`define FLME_STAT_BUSY 4'h8
`define FLME_STAT_ILLEGAL 4'h9
`define FLME_PTR_X 5'h1A
`define FLME_PTR_Y 5'h1C
`define FLME_PTR_Z 5'h1E
`define FLME_STATUS_RST 8'h00
`define FLME_INSTR_RST 32'h00000000
`endif

// file: common/flme_pkg.sv
/*
  Types of the flag, move and load execution block: operations, pointer
  and addressing modes, the instruction word and the memory request.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package flme_pkg;
  typedef enum logic [4:0] {
    FLME_OP_NOP = 5'b00000,
    FLME_OP_BIT_RAISE = 5'b00001,
    FLME_OP_BIT_LOWER = 5'b00010,
    FLME_OP_TO_T = 5'b00011,
    FLME_OP_FROM_T = 5'b00100,
    FLME_OP_CARRY_R = 5'b00101,
    FLME_OP_CARRY_L = 5'b00110,
    FLME_OP_ZERO_R = 5'b00111,
    FLME_OP_ZERO_L = 5'b01000,
    FLME_OP_NEG_R = 5'b01001,
    FLME_OP_NEG_L = 5'b01010,
    FLME_OP_OVF_R = 5'b01011,
    FLME_OP_OVF_L = 5'b01100,
    FLME_OP_SIGN_R = 5'b01101,
    FLME_OP_SIGN_L = 5'b01110,
    FLME_OP_HALF_R = 5'b01111,
    FLME_OP_HALF_L = 5'b10000,
    FLME_OP_TRANS_R = 5'b10001,
    FLME_OP_TRANS_L = 5'b10010,
    FLME_OP_INT_ON = 5'b10011,
    FLME_OP_INT_OFF = 5'b10100,
    FLME_OP_REG_COPY = 5'b10101,
    FLME_OP_PAIR_COPY = 5'b10110,
    FLME_OP_LOAD_IMM = 5'b10111,
    FLME_OP_LOAD_IND = 5'b11000
  } flme_op_type;

  typedef enum logic [1:0] {
    FLME_PTR_SEL_X = 2'b00,
    FLME_PTR_SEL_Y = 2'b01,
    FLME_PTR_SEL_Z = 2'b10
  } flme_ptr_type;

  typedef enum logic [1:0] {
    FLME_AM_PLAIN = 2'b00,
    FLME_AM_POST = 2'b01,
    FLME_AM_PRE = 2'b10,
    FLME_AM_DISP = 2'b11
  } flme_amode_type;

  typedef enum logic [1:0] {
    FLME_ST_IDLE = 2'b00,
    FLME_ST_EXEC = 2'b01,
    FLME_ST_LOAD = 2'b10
  } flme_state_type;

  // Low byte {amode, disp} doubles as the immediate of a load immediate
  typedef struct packed {
    flme_op_type op;
    logic [4:0] rd;
    logic [4:0] source_register;
    logic [2:0] bitsel;
    flme_ptr_type ptr;
    logic [3:0] spare;
    flme_amode_type amode;
    logic [5:0] disp;
  } flme_instr_type;

  typedef struct packed {
    logic rd_en;
    logic [15:0] addr;
  } flme_mem_req_type;
endpackage

// file: verilog/flme_flag_unit.sv
/*
  Next status register value for the flag raise, lower and bit copy
  operations. Pure combinational; assumes the caller applies it only
  while an instruction executes.
*/
`timescale 1ns/100ps
`include "flme_cfg.svh"
module flme_flag_unit import flme_pkg::*; (
  input wire flme_op_type op,
  input wire logic [2:0] bitsel,
  input wire logic src_bit,
  input wire logic [7:0] status_register,
  output logic [7:0] next_status
);
  // Returns {hit, value, flag index} for one operation
  function automatic logic [4:0] flag_target(input flme_op_type o, input logic [2:0] s);
    unique case (o)
      FLME_OP_BIT_RAISE: flag_target = {2'b11, s};
      FLME_OP_BIT_LOWER: flag_target = {2'b10, s};
      FLME_OP_CARRY_R: flag_target = {2'b11, `FLME_FLAG_C};
      FLME_OP_CARRY_L: flag_target = {2'b10, `FLME_FLAG_C};
      FLME_OP_ZERO_R: flag_target = {2'b11, `FLME_FLAG_Z};
      FLME_OP_ZERO_L: flag_target = {2'b10, `FLME_FLAG_Z};
      FLME_OP_NEG_R: flag_target = {2'b11, `FLME_FLAG_N};
      FLME_OP_NEG_L: flag_target = {2'b10, `FLME_FLAG_N};
      FLME_OP_OVF_R: flag_target = {2'b11, `FLME_FLAG_V};
      FLME_OP_OVF_L: flag_target = {2'b10, `FLME_FLAG_V};
      FLME_OP_SIGN_R: flag_target = {2'b11, `FLME_FLAG_S};
      FLME_OP_SIGN_L: flag_target = {2'b10, `FLME_FLAG_S};
      FLME_OP_HALF_R: flag_target = {2'b11, `FLME_FLAG_H};
      FLME_OP_HALF_L: flag_target = {2'b10, `FLME_FLAG_H};
      FLME_OP_TRANS_R: flag_target = {2'b11, `FLME_FLAG_T};
      FLME_OP_TRANS_L: flag_target = {2'b10, `FLME_FLAG_T};
      FLME_OP_INT_ON: flag_target = {2'b11, `FLME_FLAG_I};
      FLME_OP_INT_OFF: flag_target = {2'b10, `FLME_FLAG_I};
      default: flag_target = 5'h00;
    endcase
  endfunction

  logic [4:0] target;

  always_comb begin
    target = flag_target(op, bitsel);
    next_status = status_register;
    if (target[4]) begin
      next_status[target[2:0]] = target[3];
    end
    if (op == FLME_OP_TO_T) begin
      next_status[`FLME_FLAG_T] = src_bit;
    end
  end
endmodule

// file: verilog/flme_ptr_unit.sv
/*
  Address and pointer update for the indirect loads. Pure combinational;
  assumes the pointer pairs are read from the register file by the caller.
*/
`timescale 1ns/100ps
`include "flme_cfg.svh"
module flme_ptr_unit import flme_pkg::*; (
  input wire flme_instr_type instr,
  input wire logic [15:0] ptr_x,
  input wire logic [15:0] ptr_y,
  input wire logic [15:0] ptr_z,
  output logic [15:0] ptr_cur,
  output logic [4:0] ptr_lo,
  output logic [15:0] addr,
  output logic [15:0] ptr_new,
  output logic ptr_upd,
  output logic legal
);
  always_comb begin
    unique case (instr.ptr)
      FLME_PTR_SEL_X: ptr_cur = ptr_x;
      FLME_PTR_SEL_Y: ptr_cur = ptr_y;
      default: ptr_cur = ptr_z;
    endcase
    unique case (instr.ptr)
      FLME_PTR_SEL_X: ptr_lo = `FLME_PTR_X;
      FLME_PTR_SEL_Y: ptr_lo = `FLME_PTR_Y;
      default: ptr_lo = `FLME_PTR_Z;
    endcase
    addr = ptr_cur;
    ptr_new = ptr_cur;
    ptr_upd = 1'b0;
    legal = 1'b0;
    unique case (instr.amode)
      FLME_AM_PLAIN: legal = (instr.ptr != 2'b11);
      FLME_AM_POST: begin
        legal = (instr.ptr == FLME_PTR_SEL_X) || (instr.ptr == FLME_PTR_SEL_Y);
        ptr_new = 16'(ptr_cur + 16'h0001);
        ptr_upd = 1'b1;
      end
      FLME_AM_PRE: begin
        legal = (instr.ptr == FLME_PTR_SEL_X) || (instr.ptr == FLME_PTR_SEL_Y);
        ptr_new = 16'(ptr_cur - 16'h0001);
        addr = ptr_new;
        ptr_upd = 1'b1;
      end
      FLME_AM_DISP: begin
        legal = (instr.ptr == FLME_PTR_SEL_Y);
        addr = 16'(ptr_cur + {10'h000, instr.disp});
      end
    endcase
  end
endmodule

// file: verilog/flme_exec_top.sv
/*
  Execution of flag raise/lower, bit copy, register moves and indirect
  loads, with the 32 x 8 register file and the status register inside.
  Software issues instructions and inspects state over AXI4-Lite; the
  data memory must answer a read in the same cycle its request is high.
*/
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "flme_cfg.svh"
module flme_exec_top import flme_pkg::*; (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output flme_mem_req_type mem_req,
  input wire logic [7:0] mem_rd_data
);
  // ==========================================================
  // Declarations
  logic [7:0] gpr [0:31];
  flme_state_type st, next_st;
  flme_instr_type instr, next_instr;
  logic [7:0] status_register, next_status, flag_status;
  logic illegal, next_illegal;
  logic [4:0] sel, next_sel;
  flme_mem_req_type next_mem;
  logic wa_en, wb_en;
  logic [4:0] wa_idx, wb_idx;
  logic [7:0] wa_data, wb_data;
  logic aw_have, next_aw_have, w_have, next_w_have;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic do_write, wr_instr, wr_status, wr_sel, wr_gpr, ar_take;
  logic go;
  logic [7:0] rd_val, source_value, bit_ins;
  logic src_bit;
  logic [15:0] ptr_cur, load_addr, ptr_new;
  logic [4:0] ptr_lo;
  logic ptr_upd, load_legal;

  // Byte lane merge for word-wide registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction

  assign go = (st == FLME_ST_EXEC);
  assign rd_val = gpr[instr.rd];
  assign source_value = gpr[instr.source_register];
  assign src_bit = source_value[instr.bitsel];

  always_comb begin
    bit_ins = rd_val;
    bit_ins[instr.bitsel] = status_register[`FLME_FLAG_T];
  end

  // ==========================================================
  // Helpers
  flme_flag_unit u_flag (
    .op(instr.op),
    .bitsel(instr.bitsel),
    .src_bit(src_bit),
    .status_register(status_register),
    .next_status(flag_status)
  );

  flme_ptr_unit u_ptr (
    .instr(instr),
    .ptr_x({gpr[`FLME_PTR_X + 5'h01], gpr[`FLME_PTR_X]}),
    .ptr_y({gpr[`FLME_PTR_Y + 5'h01], gpr[`FLME_PTR_Y]}),
    .ptr_z({gpr[`FLME_PTR_Z + 5'h01], gpr[`FLME_PTR_Z]}),
    .ptr_cur(ptr_cur),
    .ptr_lo(ptr_lo),
    .addr(load_addr),
    .ptr_new(ptr_new),
    .ptr_upd(ptr_upd),
    .legal(load_legal)
  );

  // ==========================================================
  // AXI4-Lite slave
  // Writes are only finished while idle, so software never races execution
  assign do_write = aw_have && w_have && !s_axi_bvalid && (st == FLME_ST_IDLE);
  assign wr_instr = do_write && (aw_addr == `FLME_ADDR_INSTR);
  assign wr_status = do_write && (aw_addr == `FLME_ADDR_STATUS) && w_strb[0];
  assign wr_sel = do_write && (aw_addr == `FLME_ADDR_SEL) && w_strb[0];
  assign wr_gpr = do_write && (aw_addr == `FLME_ADDR_GPR) && w_strb[0];
  assign ar_take = s_axi_arvalid && s_axi_arready;

  always_comb begin
    next_aw_have = aw_have || (s_axi_awvalid && s_axi_awready);
    next_w_have = w_have || (s_axi_wvalid && s_axi_wready);
    next_aw_addr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr;
    next_w_data = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_data;
    next_w_strb = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : w_strb;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    if (do_write) begin
      next_aw_have = 1'b0;
      next_w_have = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (aw_addr == `FLME_ADDR_INSTR || aw_addr == `FLME_ADDR_STATUS ||
                    aw_addr == `FLME_ADDR_SEL || aw_addr == `FLME_ADDR_GPR) ?
                   `FLME_RESP_OKAY : `FLME_RESP_SLVERR;
    end
    next_awready = !next_aw_have && !next_bvalid && (next_st == FLME_ST_IDLE);
    next_wready = !next_w_have && !next_bvalid && (next_st == FLME_ST_IDLE);
    next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);
    next_arready = !next_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (ar_take) begin
      next_rresp = `FLME_RESP_OKAY;
      unique case (s_axi_araddr)
        `FLME_ADDR_INSTR: next_rdata = instr;
        `FLME_ADDR_STATUS: next_rdata = {22'h000000, illegal, (st != FLME_ST_IDLE),
                                         status_register};
        `FLME_ADDR_SEL: next_rdata = {27'h0000000, sel};
        `FLME_ADDR_GPR: next_rdata = {24'h000000, gpr[sel]};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = `FLME_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // ==========================================================
  // Execution sequencer
  always_comb begin
    next_st = st;
    next_instr = instr;
    next_status = status_register;
    next_illegal = illegal;
    next_sel = wr_sel ? w_data[4:0] : sel;
    next_mem = '{rd_en: 1'b0, addr: mem_req.addr};
    wa_en = 1'b0;
    wa_idx = instr.rd;
    wa_data = 8'h00;
    wb_en = 1'b0;
    wb_idx = instr.rd;
    wb_data = 8'h00;
    if (wr_status) begin
      next_status = w_data[7:0];
      next_illegal = illegal && !w_data[`FLME_STAT_ILLEGAL];
    end
    if (wr_gpr) begin
      wa_en = 1'b1;
      wa_idx = sel;
      wa_data = w_data[7:0];
    end
    unique case (st)
      FLME_ST_IDLE: begin
        if (wr_instr) begin
          next_instr = merge(instr, w_data, w_strb);
          next_st = FLME_ST_EXEC;
        end
      end
      FLME_ST_EXEC: begin
        next_st = FLME_ST_IDLE;
        if (instr.op == FLME_OP_LOAD_IND) begin
          if (load_legal) begin
            // Address phase: request out, pointer written back now in post/pre modes
            next_mem = '{rd_en: 1'b1, addr: load_addr};
            wa_en = ptr_upd;
            wa_idx = ptr_lo;
            wa_data = ptr_new[7:0];
            wb_en = ptr_upd;
            wb_idx = ptr_lo + 5'h01;
            wb_data = ptr_new[15:8];
            next_st = FLME_ST_LOAD;
          end else begin
            // Unsupported pointer/mode pair; set wins over a clear
            next_illegal = 1'b1;
          end
        end else begin
          next_status = flag_status;
          unique case (instr.op)
            FLME_OP_REG_COPY: begin
              wa_en = 1'b1;
              wa_data = source_value;
            end
            FLME_OP_PAIR_COPY: begin
              wa_en = 1'b1;
              wa_idx = {instr.rd[4:1], 1'b0};
              wa_data = gpr[{instr.source_register[4:1], 1'b0}];
              wb_en = 1'b1;
              wb_idx = {instr.rd[4:1], 1'b1};
              wb_data = gpr[{instr.source_register[4:1], 1'b1}];
            end
            FLME_OP_LOAD_IMM: begin
              wa_en = 1'b1;
              wa_data = {instr.amode, instr.disp};
            end
            FLME_OP_FROM_T: begin
              wa_en = 1'b1;
              wa_data = bit_ins;
            end
            default: wa_en = 1'b0;
          endcase
        end
      end
      FLME_ST_LOAD: begin
        wa_en = 1'b1;
        wa_data = mem_rd_data;
        next_st = FLME_ST_IDLE;
      end
      default: next_st = FLME_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= FLME_ST_IDLE;
      instr <= `FLME_INSTR_RST;
      status_register <= `FLME_STATUS_RST;
      illegal <= 1'b0;
      sel <= 5'h00;
      mem_req <= '{rd_en: 1'b0, addr: 16'h0000};
    end else begin
      st <= next_st;
      instr <= next_instr;
      status_register <= next_status;
      illegal <= next_illegal;
      sel <= next_sel;
      mem_req <= next_mem;
    end
  end

  // Register file: two write ports, port B covers pair and pointer high bytes
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 32; i++) begin
        gpr[i] <= 8'h00;
      end
    end else begin
      if (wa_en) begin
        gpr[wa_idx] <= wa_data;
      end
      if (wb_en) begin
        gpr[wb_idx] <= wb_data;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_load_go(flme_amode_type m);
    go && instr.op == FLME_OP_LOAD_IND && instr.amode == m && load_legal;
  endsequence

  sequence s_load_finish;
    st == FLME_ST_IDLE && !mem_req.rd_en && rd_val == $past(mem_rd_data) &&
      $stable(status_register);
  endsequence

  a_bit_to_transfer: assert property (
    go && instr.op == FLME_OP_TO_T |=> status_register[6] == $past(src_bit) &&
      {status_register[7], status_register[5:0]} ==
      {$past(status_register[7]), $past(status_register[5:0])})
    else $error("transfer flag copy wrong");
  a_transfer_to_bit: assert property (
    go && instr.op == FLME_OP_FROM_T |=> rd_val[instr.bitsel] == status_register[6] &&
      $stable(status_register))
    else $error("bit load from transfer flag wrong");
  a_int_on_flag: assert property (
    go && instr.op == FLME_OP_INT_ON |=> status_register[7] &&
      status_register[6:0] == $past(status_register[6:0]))
    else $error("interrupt enable not set alone");
  a_int_off_flag: assert property (
    go && instr.op == FLME_OP_INT_OFF |=> !status_register[7] &&
      status_register[6:0] == $past(status_register[6:0]))
    else $error("interrupt enable not cleared alone");
  a_sign_flag_force: assert property (
    go && (instr.op == FLME_OP_SIGN_R || instr.op == FLME_OP_SIGN_L) |=>
      status_register[4] == (instr.op == FLME_OP_SIGN_R) &&
      status_register[3:0] == $past(status_register[3:0]))
    else $error("sign flag force wrong");
  a_ovf_raise_only: assert property (
    go && instr.op == FLME_OP_OVF_R |=> status_register == ($past(status_register) | 8'h08))
    else $error("overflow raise wrong");
  a_ovf_lower_only: assert property (
    go && instr.op == FLME_OP_OVF_L |=> status_register == ($past(status_register) & 8'hF7))
    else $error("overflow lower wrong");
  a_half_raise_only: assert property (
    go && instr.op == FLME_OP_HALF_R |=> status_register == ($past(status_register) | 8'h20))
    else $error("half carry raise wrong");
  a_half_lower_only: assert property (
    go && instr.op == FLME_OP_HALF_L |=> status_register == ($past(status_register) & 8'hDF))
    else $error("half carry lower wrong");
  a_reg_copy_move: assert property (
    go && instr.op == FLME_OP_REG_COPY |=> rd_val == $past(source_value) &&
      $stable(status_register) && st == FLME_ST_IDLE)
    else $error("register copy wrong");
  a_post_inc_load: assert property (
    s_load_go(FLME_AM_POST) |=> mem_req.rd_en && mem_req.addr == $past(ptr_cur) &&
      ptr_cur == 16'($past(ptr_cur) + 16'h0001) ##1 s_load_finish)
    else $error("post increment load wrong");
  a_pre_dec_load: assert property (
    s_load_go(FLME_AM_PRE) |=> mem_req.rd_en && ptr_cur == 16'($past(ptr_cur) - 16'h0001) &&
      mem_req.addr == ptr_cur ##1 s_load_finish)
    else $error("pre decrement load wrong");
  a_disp_load_addr: assert property (
    s_load_go(FLME_AM_DISP) |=> mem_req.rd_en && $stable(ptr_cur) &&
      mem_req.addr == 16'($past(ptr_cur) + {10'h000, instr.disp}) ##1 s_load_finish)
    else $error("displaced load wrong");
  a_generic_raise_lower: assert property (
    go && (instr.op == FLME_OP_BIT_RAISE || instr.op == FLME_OP_BIT_LOWER) |=>
      status_register[instr.bitsel] == (instr.op == FLME_OP_BIT_RAISE))
    else $error("generic flag force wrong");
  a_pair_copy_move: assert property (
    go && instr.op == FLME_OP_PAIR_COPY |=> $stable(status_register) && st == FLME_ST_IDLE &&
      gpr[{instr.rd[4:1], 1'b1}] == $past(gpr[{instr.source_register[4:1], 1'b1}]))
    else $error("pair copy wrong");
endmodule

// file: test/flme_mem_model.sv
/*
  Data memory model for the execution block.
  Assumes a one-cycle read pulse that it answers in the same cycle.
*/
`timescale 1ns/100ps
module flme_mem_model import flme_pkg::*; (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire flme_mem_req_type mem_req,
  output logic [7:0] mem_rd_data
);
  // ============================================================
  // Read path
  logic [7:0] junk;
  // Idle bus moves every cycle so a late sample cannot match
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) junk <= 8'h00;
    else junk <= junk + 8'h35;
  end
  assign mem_rd_data = mem_req.rd_en ?
    (mem_req.addr[7:0] ^ mem_req.addr[15:8] ^ 8'h3C) : junk;
endmodule

// file: test/test_flag_and_load_move_exec.sv
/*
  Self-checking bench: AXI4-Lite master, memory model, read monitor.
  Assumes the execution block and its memory model are compiled first.
*/
`timescale 1ns/100ps
`include "flme_cfg.svh"
module test_flag_and_load_move_exec import flme_pkg::*;;
  logic ref_clk = 1'b0, sys_rst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00, mrd;
  logic [31:0] wd = 32'h0, rdt, s, r;
  logic awr, wrd, bv, arr, rv;
  logic [1:0] br, rsp;
  logic [9:0] qb[$], y;
  flme_mem_req_type mreq;
  logic [41:0] q[$];
  logic [41:0] x;
  logic [7:0] e, p8;
  logic [15:0] p, a, np;
  logic [5:0] dq;
  logic [4:0] b;
  logic [2:0] f;
  logic [1:0] pl[7] = '{0, 0, 1, 1, 1, 2, 0};
  logic [1:0] am[7] = '{1, 2, 1, 2, 3, 0, 0};
  int n_fail = 0, n_tests = 0, cyc = 0, i;
  logic [31:0] seed;
  flme_exec_top flme_exec_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(rsp), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .mem_req(mreq), .mem_rd_data(mrd));
  flme_mem_model flme_mem_model_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .mem_req(mreq), .mem_rd_data(mrd));
  // ============================================================
  // Bus tasks
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic pa;
    logic pw;
    @(posedge ref_clk);
    awa <= ad;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    qb.push_back({ad, (ad inside {`FLME_ADDR_INSTR, `FLME_ADDR_STATUS, `FLME_ADDR_SEL,
      `FLME_ADDR_GPR}) ? `FLME_RESP_OKAY : `FLME_RESP_SLVERR});
    while (pa | pw) begin
      @(negedge ref_clk);
      if (awr === 1'b1) pa = 1'b0;
      if (wrd === 1'b1) pw = 1'b0;
      @(posedge ref_clk);
      awv <= pa;
      wv <= pw;
    end
    do @(negedge ref_clk); while (bv !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [33:0] ex);
    @(posedge ref_clk);
    ara <= ad;
    arv <= 1'b1;
    q.push_back({ad, ex});
    do @(negedge ref_clk); while (arr !== 1'b1);
    @(posedge ref_clk);
    arv <= 1'b0;
    do @(negedge ref_clk); while (rv !== 1'b1);
  endtask
  task automatic setr(input logic [4:0] ix, input logic [7:0] v);
    wr(`FLME_ADDR_SEL, {27'h0, ix});
    wr(`FLME_ADDR_GPR, {24'h0, v});
  endtask
  task automatic chk(input logic [4:0] ix, input logic [7:0] v);
    wr(`FLME_ADDR_SEL, {27'h0, ix});
    rd(`FLME_ADDR_GPR, {26'h0, v});
  endtask
  function automatic logic [31:0] ins(input logic [4:0] op, d, sr,
    input logic [2:0] bs, input logic [1:0] pt, md, input logic [5:0] dp);
    return {op, d, sr, bs, pt, 4'h0, md, dp};
  endfunction
  function automatic logic [33:0] sx(input logic il, input logic [7:0] sr);
    return {2'h0, 22'h0, il, 1'b0, sr};
  endfunction
  task test_done;
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ============================================================
  // Monitor and clock
  always @(negedge ref_clk) begin
    if (bv === 1'b1) begin
      y = qb.pop_front();
      n_tests++;
      if (br !== y[1:0]) begin
        n_fail++;
        $display("BAD wr %h exp %h got %h", y[9:2], y[1:0], br);
      end
    end
    if (rv === 1'b1) begin
      x = q.pop_front();
      n_tests++;
      if ({rsp, rdt} !== x[33:0]) begin
        n_fail++;
        $display("BAD rd %h exp %h got %h", x[41:34], x[33:0], {rsp, rdt});
      end
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done;
    end
  end
  initial forever #20 ref_clk = ~ref_clk;
  // ============================================================
  // Scenarios
  initial begin
    seed = 32'h06e43e16;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 18; i++) begin
      s = $random(seed);
      f = (i < 16) ? i[3:1] : s[10:8];
      e = s[7:0];
      e[f] = (i < 16) ? ~i[0] : (i == 16);
      wr(`FLME_ADDR_STATUS, {24'h0, s[7:0]});
      wr(`FLME_ADDR_INSTR, ins((i < 16) ? 5'(5 + i) : 5'(i - 15), 0, 0, f, 0, 0, 0));
      rd(`FLME_ADDR_STATUS, sx(0, e));
    end
    r = $random(seed);
    setr(3, r[7:0]);
    setr(2, r[15:8]);
    setr(5, r[23:16]);
    wr(`FLME_ADDR_INSTR, ins(3, 0, 3, s[13:11], 0, 0, 0));
    e[6] = r[s[13:11]];
    rd(`FLME_ADDR_STATUS, sx(0, e));
    wr(`FLME_ADDR_INSTR, ins(4, 5, 0, s[16:14], 0, 0, 0));
    p8 = r[23:16];
    p8[s[16:14]] = e[6];
    chk(5, p8);
    wr(`FLME_ADDR_INSTR, ins(21, 7, 3, 0, 0, 0, 0));
    chk(7, r[7:0]);
    wr(`FLME_ADDR_INSTR, ins(22, 9, 3, 0, 0, 0, 0));
    chk(8, r[15:8]);
    chk(9, r[7:0]);
    wr(`FLME_ADDR_INSTR, ins(23, 10, 0, 0, 0, s[23:22], s[21:16]));
    chk(10, s[23:16]);
    rd(`FLME_ADDR_STATUS, sx(0, e));
    for (i = 0; i < 7; i++) begin
      p = $random(seed);
      p[7:0] = p[7:0] | {8{i == 0}};
      dq = $random(seed);
      b = 5'(26 + 2 * pl[i]);
      setr(b, p[7:0]);
      setr(b + 5'h1, p[15:8]);
      wr(`FLME_ADDR_INSTR, ins(24, 5'(16 + i), 0, 0, pl[i], am[i], dq));
      a = (am[i] == 2) ? p - 16'h1 : (am[i] == 3) ? p + {10'h0, dq} : p;
      np = (am[i] == 1) ? p + 16'h1 : (am[i] == 2) ? p - 16'h1 : p;
      chk(5'(16 + i), a[7:0] ^ a[15:8] ^ 8'h3C);
      chk(b, np[7:0]);
      chk(b + 5'h1, np[15:8]);
    end
    // Pointer Z cannot post-increment: only the sticky error flag moves
    wr(`FLME_ADDR_INSTR, ins(24, 23, 0, 0, 2, 1, 0));
    wr(8'h10, 32'hFFFFFFFF);
    rd(`FLME_ADDR_STATUS, sx(1, e));
    // Writing one clears the sticky flag; a no-op after it leaves the flags alone
    wr(`FLME_ADDR_STATUS, {22'h0, 1'b1, 1'b0, e});
    wr(`FLME_ADDR_INSTR, 32'h0);
    rd(`FLME_ADDR_STATUS, sx(0, e));
    rd(8'h10, {`FLME_RESP_SLVERR, 32'h0});
    repeat (4) @(posedge ref_clk);
    test_done;
  end
endmodule
